// ### logic/reset_source_combiner.sv
/*
 * Reset source combiner: merges reset sources into the system reset,
 * records reset causes, picks the clock source after reset, AXI4-Lite slave.
 * Assumes pin sources are asynchronous and internal sources share clk.
 */
// Design decision made here: register access over AXI4-Lite.
// Contract
// - system reset is asserted while any reset source is active.
// - sources are power-on, pin, instruction, watchdog, brown-out, low-power brown-out, trap, illegal opcode, uninitialised W.
// - each reset sets the cause flag matching its type.
// - a power-on reset clears all cause flags except the two lowest, which it sets.
// - software may set or clear any cause flag at any time; a write in the cycle of a reset event does not clear the flag that event sets.
// - writing a cause flag never starts a reset.
// - registers without reset value keep contents on non-power-on resets; others take their value.
// - with switching on, power-on and brown-out take the oscillator configuration bits, others keep the current one.
// - with switching off, every reset takes the oscillator configuration bits.
// - oscillator reset value depends on reset type and fuses, cause reset value on reset type.
// - the two scratch registers are cleared only by power-on.
// - system reset is released only after the power-on delay (power-on only) and, if enabled, the power-up timer delay (power-on and brown-out).
// - cause bit 13 is the software brown-out enable in mode 01 and reads zero otherwise.
`timescale 1ns/10ps
`default_nettype none
module reset_source_combiner #(
    parameter int POWER_UP_TIMER_CYCLES      = rsc_pkg::POWER_UP_TIMER_CYCLES,
    parameter int POR_DELAY_CYCLES = rsc_pkg::POR_DELAY_CYCLES,
    parameter int TIMER_W          = 24
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [15:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [15:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        powerOnPin,
    input  wire logic        externalResetPin,
    input  wire logic        brownoutPin,
    input  wire logic        lowPowerBrownoutPin,
    input  wire logic        softwareResetReq,
    input  wire logic        watchdogResetSource,
    input  wire logic        trapConflictReq,
    input  wire logic        illegalOpcodeReq,
    input  wire logic        uninitWregReset,
    output logic             systemResetSignal,
    output logic [2:0]       currentOscSel,
    output logic             brownoutDetectEnable,
    output logic             irq
);
    if (POWER_UP_TIMER_CYCLES + POR_DELAY_CYCLES >= 2 ** TIMER_W || POR_DELAY_CYCLES < 1) begin : g_chk
        $error("delay counts do not fit the timer");
    end

    // =====================================================================
    // source capture
    // =====================================================================
    localparam int NS = rsc_pkg::NUM_SRC;
    localparam int NP = rsc_pkg::NUM_PIN;
    logic [NP-1:0] pinRaw, s1, s2, s3, pinLevel, next_pinLevel;
    logic [NS-1:0] srcNow, srcPrev, srcEvent;
    logic          anySrc, porEvent, borEvent, anyEvent;

    assign pinRaw = {lowPowerBrownoutPin, brownoutPin, externalResetPin, powerOnPin};
    for (genvar i = 0; i < NP; i++) begin : g_pin
        assign next_pinLevel[i] = (s2[i] == s3[i]) ? s3[i] : pinLevel[i];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1       <= '0;
            s2       <= '0;
            s3       <= '0;
            pinLevel <= '0;
            srcPrev  <= '0;
        end else begin
            s1       <= pinRaw;
            s2       <= s1;
            s3       <= s2;
            pinLevel <= next_pinLevel;
            srcPrev  <= srcNow;
        end
    end

    assign srcNow = {uninitWregReset, illegalOpcodeReq, trapConflictReq, watchdogResetSource,
                     softwareResetReq, pinLevel};
    assign srcEvent = srcNow & ~srcPrev;
    assign anySrc   = |srcNow;
    assign porEvent = srcEvent[rsc_pkg::SRC_POR];
    assign borEvent = srcEvent[rsc_pkg::SRC_BROWN] | srcEvent[rsc_pkg::SRC_LPBROWN];
    assign anyEvent = |srcEvent;

    // =====================================================================
    // release delay
    // =====================================================================
    logic [15:0] cfg;
    logic        pwrtOn, porFell, borFell, next_system_reset_signal;
    rsc_timer_if #(.W(TIMER_W)) tmr ();

    rsc_delay_timer #(.W(TIMER_W)) u_timer (
        .clk (clk),
        .rst (rst),
        .tmr (tmr.timer)
    );

    assign pwrtOn  = cfg[rsc_pkg::CFG_POWER_UP_TIMER];
    assign porFell = srcPrev[rsc_pkg::SRC_POR] & ~srcNow[rsc_pkg::SRC_POR];
    assign borFell = (srcPrev[rsc_pkg::SRC_BROWN] & ~srcNow[rsc_pkg::SRC_BROWN])
                   | (srcPrev[rsc_pkg::SRC_LPBROWN] & ~srcNow[rsc_pkg::SRC_LPBROWN]);

    always_comb begin
        tmr.loadCycles = '0;
        if (porFell) begin
            tmr.loadCycles = TIMER_W'(POR_DELAY_CYCLES) + (pwrtOn ? TIMER_W'(POWER_UP_TIMER_CYCLES) : '0);
        end else if (borFell && pwrtOn) begin
            tmr.loadCycles = TIMER_W'(POWER_UP_TIMER_CYCLES);
        end
        tmr.start   = (tmr.loadCycles != '0);
        next_system_reset_signal = anySrc | tmr.busy | tmr.start;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            systemResetSignal <= 1'b1;
        end else begin
            systemResetSignal <= next_system_reset_signal;
        end
    end

    // =====================================================================
    // AXI4-Lite slave
    // =====================================================================
    logic        awHeld, wHeld, next_awHeld, next_wHeld, next_bvalid, next_rvalid;
    logic [13:0] awIdx, next_awIdx;
    logic [15:0] wData, next_wData;
    logic [1:0]  wStrb, next_wStrb, next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic        doWrite, doRead;
    logic [13:0] arIdx;
    logic [15:0] causeRd, readVal;
    logic        readHit;

    assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
    assign s_axi_wready  = ~wHeld & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign doWrite       = awHeld & wHeld & ~s_axi_bvalid;
    assign doRead        = s_axi_arvalid & s_axi_arready;
    assign arIdx         = s_axi_araddr[15:2];

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] d,
                                            input logic [1:0] strb);
        merge16 = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
    endfunction

    function automatic logic hit(input logic [13:0] idx);
        hit = idx inside {rsc_pkg::CAUSE_IDX, rsc_pkg::OSC_IDX, rsc_pkg::SCRATCH0_IDX,
                          rsc_pkg::SCRATCH1_IDX, rsc_pkg::CFG_IDX, rsc_pkg::IRQ_STAT_IDX,
                          rsc_pkg::IRQ_MASK_IDX};
    endfunction

    always_comb begin
        next_awHeld = awHeld;
        next_awIdx  = awIdx;
        next_wHeld  = wHeld;
        next_wData  = wData;
        next_wStrb  = wStrb;
        next_bvalid = s_axi_bvalid;
        next_bresp  = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rdata  = s_axi_rdata;
        next_rresp  = s_axi_rresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_awHeld = 1'b1;
            next_awIdx  = s_axi_awaddr[15:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_wHeld = 1'b1;
            next_wData = s_axi_wdata[15:0];
            next_wStrb = s_axi_wstrb[1:0];
        end
        if (doWrite) begin
            next_awHeld = 1'b0;
            next_wHeld  = 1'b0;
            next_bvalid = 1'b1;
            next_bresp  = hit(awIdx) ? rsc_pkg::RESP_OKAY : rsc_pkg::RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (doRead) begin
            next_rvalid = 1'b1;
            next_rdata  = {16'h0000, readVal};
            next_rresp  = readHit ? rsc_pkg::RESP_OKAY : rsc_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            awHeld       <= 1'b0;
            awIdx        <= '0;
            wHeld        <= 1'b0;
            wData        <= '0;
            wStrb        <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= rsc_pkg::RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= rsc_pkg::RESP_OKAY;
        end else begin
            awHeld       <= next_awHeld;
            awIdx        <= next_awIdx;
            wHeld        <= next_wHeld;
            wData        <= next_wData;
            wStrb        <= next_wStrb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp  <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= next_rresp;
        end
    end

    // =====================================================================
    // registers
    // =====================================================================
    logic [15:0] cause, scratch0, scratch1, next_cause, next_scratch0, next_scratch1;
    logic [15:0] next_cfg, causeSet;
    logic [2:0]  curOsc, newOsc, next_curOsc, next_newOsc, resetOsc;
    logic        oscSwitch, next_oscSwitch, clkSwOn;
    logic [1:0]  bMode;
    logic [NS-1:0] irqStat, irqMask, next_irqStat, next_irqMask;
    logic        wrCause, wrOsc;

    assign clkSwOn = cfg[rsc_pkg::CFG_CLK_SW];
    assign bMode   = cfg[rsc_pkg::CFG_BMODE +: 2];
    assign wrCause = doWrite && awIdx == rsc_pkg::CAUSE_IDX;
    assign wrOsc   = doWrite && awIdx == rsc_pkg::OSC_IDX;
    assign causeRd = (bMode == rsc_pkg::BMODE_SOFT) ? cause
                   : (cause & ~(16'h0001 << rsc_pkg::CAUSE_SW_BOR));

    always_comb begin
        causeSet = '0;
        causeSet[rsc_pkg::CAUSE_EXT]     = srcEvent[rsc_pkg::SRC_EXT];
        causeSet[rsc_pkg::CAUSE_SW]      = srcEvent[rsc_pkg::SRC_SW];
        causeSet[rsc_pkg::CAUSE_WDT]     = srcEvent[rsc_pkg::SRC_WDT];
        causeSet[rsc_pkg::CAUSE_BROWN]   = borEvent;
        causeSet[rsc_pkg::CAUSE_TRAP]    = srcEvent[rsc_pkg::SRC_TRAP];
        causeSet[rsc_pkg::CAUSE_ILLEGAL] = srcEvent[rsc_pkg::SRC_ILLEGAL]
                                         | srcEvent[rsc_pkg::SRC_UWR];
        readHit = hit(arIdx);
        unique case (1'b1)
            arIdx == rsc_pkg::CAUSE_IDX:    readVal = causeRd;
            arIdx == rsc_pkg::OSC_IDX:      readVal = {1'b0, curOsc, 1'b0, newOsc, 7'h00, oscSwitch};
            arIdx == rsc_pkg::SCRATCH0_IDX: readVal = scratch0;
            arIdx == rsc_pkg::SCRATCH1_IDX: readVal = scratch1;
            arIdx == rsc_pkg::CFG_IDX:      readVal = cfg;
            arIdx == rsc_pkg::IRQ_STAT_IDX: readVal = 16'(irqStat);
            arIdx == rsc_pkg::IRQ_MASK_IDX: readVal = 16'(irqMask);
            default:                        readVal = 16'h0000;
        endcase
    end

    always_comb begin
        next_cause    = cause;
        next_scratch0 = scratch0;
        next_scratch1 = scratch1;
        next_cfg      = cfg;
        next_curOsc   = curOsc;
        next_newOsc   = newOsc;
        next_oscSwitch = oscSwitch;
        next_irqMask  = irqMask;
        next_irqStat  = irqStat;
        if (wrCause) begin
            next_cause = merge16(cause, wData, wStrb) & rsc_pkg::CAUSE_IMPL_MASK;
        end
        next_cause = next_cause | causeSet;
        if (porEvent) begin
            next_cause = rsc_pkg::CAUSE_POR_VALUE;
        end
        if (doWrite && awIdx == rsc_pkg::SCRATCH0_IDX) next_scratch0 = merge16(scratch0, wData, wStrb);
        if (doWrite && awIdx == rsc_pkg::SCRATCH1_IDX) next_scratch1 = merge16(scratch1, wData, wStrb);
        if (porEvent) begin
            next_scratch0 = '0;
            next_scratch1 = '0;
        end
        if (doWrite && awIdx == rsc_pkg::CFG_IDX) next_cfg = merge16(cfg, wData, wStrb);
        if (doWrite && awIdx == rsc_pkg::IRQ_MASK_IDX) begin
            next_irqMask = NS'(merge16(16'(irqMask), wData, wStrb));
        end
        if (oscSwitch) begin
            next_curOsc    = newOsc;
            next_oscSwitch = 1'b0;
        end
        if (wrOsc) begin
            if (wStrb[1]) next_newOsc = wData[rsc_pkg::OSC_NEW_LSB +: 3];
            if (wStrb[0]) next_oscSwitch = wData[rsc_pkg::OSC_SWITCH];
        end
        resetOsc = (clkSwOn && !(porEvent || borEvent)) ? curOsc
                 : cfg[rsc_pkg::CFG_NOSC +: 3];
        if (anyEvent) begin
            next_curOsc    = resetOsc;
            next_newOsc    = resetOsc;
            next_oscSwitch = 1'b0;
        end
        if (doRead && arIdx == rsc_pkg::IRQ_STAT_IDX) next_irqStat = '0;
        next_irqStat = next_irqStat | srcEvent;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cause     <= rsc_pkg::CAUSE_POR_VALUE;
            scratch0  <= '0;
            scratch1  <= '0;
            cfg       <= rsc_pkg::CFG_RESET;
            curOsc    <= rsc_pkg::OSC_RESET;
            newOsc    <= rsc_pkg::OSC_RESET;
            oscSwitch <= 1'b0;
            irqStat   <= '0;
            irqMask   <= '0;
            irq       <= 1'b0;
        end else begin
            cause     <= next_cause;
            scratch0  <= next_scratch0;
            scratch1  <= next_scratch1;
            cfg       <= next_cfg;
            curOsc    <= next_curOsc;
            newOsc    <= next_newOsc;
            oscSwitch <= next_oscSwitch;
            irqStat   <= next_irqStat;
            irqMask   <= next_irqMask;
            irq       <= |(next_irqStat & next_irqMask);
        end
    end

    assign currentOscSel        = curOsc;
    assign brownoutDetectEnable = (bMode != rsc_pkg::BMODE_OFF)
                                && (bMode != rsc_pkg::BMODE_SOFT || cause[rsc_pkg::CAUSE_SW_BOR]);

    // =====================================================================
    // checks
    // =====================================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_quiet;
        !anySrc && !tmr.busy && !tmr.start;
    endsequence

    chk_any_source : assert property (anySrc |=> systemResetSignal)
        else $error("source active without system reset");
    chk_cause_por : assert property (porEvent |=> cause == 16'h0003)
        else $error("power-on cause value wrong");
    chk_cause_wdt : assert property (srcEvent[rsc_pkg::SRC_WDT] && !porEvent
        |=> cause[rsc_pkg::CAUSE_WDT])
        else $error("watchdog flag not set");
    chk_hw_wins : assert property (wrCause && !porEvent
        |=> (cause & $past(causeSet)) == $past(causeSet))
        else $error("write beat hardware flag");
    chk_write_no_reset : assert property (wrCause ##0 s_quiet |=> !systemResetSignal)
        else $error("cause write caused reset");
    chk_sbor_masked : assert property (bMode != rsc_pkg::BMODE_SOFT |-> !causeRd[13])
        else $error("soft brown-out bit visible");
    chk_osc_power : assert property (porEvent |=> curOsc == $past(cfg[10:8]))
        else $error("power-on clock source wrong");
    chk_osc_keep : assert property (
        (srcEvent[rsc_pkg::SRC_EXT] || srcEvent[rsc_pkg::SRC_WDT] || srcEvent[rsc_pkg::SRC_SW])
        && !porEvent && !borEvent && clkSwOn && !oscSwitch |=> $stable(curOsc))
        else $error("kept clock source changed");
    chk_osc_fixed : assert property (anyEvent && !clkSwOn |=> curOsc == $past(cfg[10:8]))
        else $error("clock source not from config");
    chk_scratch_keep : assert property (anyEvent && !porEvent && !doWrite
        |=> $stable(scratch0) && $stable(scratch1))
        else $error("scratch lost on reset");
    chk_release_wait : assert property (porFell ##1 1 |-> systemResetSignal [*2])
        else $error("released before delay");

endmodule // reset_source_combiner
`default_nettype wire

// ### logic/rsc_pkg.sv
/*
 * Constants shared by the reset source combiner: register indices, field
 * positions, reset values, source numbering and delay figures.
 * Assumes a 125 MHz system clock.
 */
`default_nettype none
package rsc_pkg;

    // =====================================================================
    // register indices, byte address is four times the index
    // =====================================================================
    localparam logic [13:0] CAUSE_IDX    = 14'h0740;
    localparam logic [13:0] OSC_IDX      = 14'h0742;
    localparam logic [13:0] SCRATCH0_IDX = 14'h075C;
    localparam logic [13:0] SCRATCH1_IDX = 14'h075E;
    localparam logic [13:0] CFG_IDX      = 14'h0760;
    localparam logic [13:0] IRQ_STAT_IDX = 14'h0762;
    localparam logic [13:0] IRQ_MASK_IDX = 14'h0764;

    // =====================================================================
    // reset cause register fields
    // =====================================================================
    localparam int CAUSE_TRAP    = 15;
    localparam int CAUSE_ILLEGAL = 14;
    localparam int CAUSE_SW_BOR  = 13;
    localparam int CAUSE_EXT     = 7;
    localparam int CAUSE_SW      = 6;
    localparam int CAUSE_WDT     = 4;
    localparam int CAUSE_BROWN   = 1;
    localparam logic [15:0] CAUSE_IMPL_MASK = 16'hF7FF;
    localparam logic [15:0] CAUSE_POR_VALUE = 16'h0003;

    // =====================================================================
    // oscillator control and configuration fields
    // =====================================================================
    localparam int OSC_CUR_LSB = 12;
    localparam int OSC_NEW_LSB = 8;
    localparam int OSC_SWITCH  = 0;
    localparam int CFG_CLK_SW  = 0;
    localparam int CFG_POWER_UP_TIMER    = 1;
    localparam int CFG_BMODE   = 2;
    localparam int CFG_NOSC    = 8;
    localparam logic [15:0] CFG_RESET   = 16'h0001;
    localparam logic [2:0]  OSC_RESET   = 3'h0;
    localparam logic [1:0]  BMODE_SOFT  = 2'h1;
    localparam logic [1:0]  BMODE_OFF   = 2'h0;

    // =====================================================================
    // reset sources
    // =====================================================================
    localparam int NUM_SRC    = 9;
    localparam int NUM_PIN    = 4;
    localparam int SRC_POR    = 0;
    localparam int SRC_EXT    = 1;
    localparam int SRC_BROWN  = 2;
    localparam int SRC_LPBROWN = 3;
    localparam int SRC_SW     = 4;
    localparam int SRC_WDT    = 5;
    localparam int SRC_TRAP   = 6;
    localparam int SRC_ILLEGAL = 7;
    localparam int SRC_UWR    = 8;

    // =====================================================================
    // delays
    // =====================================================================
    localparam int CLK_FREQ_KHZ     = 125000;
    localparam int POWER_UP_TIMER_TIME_MS     = 64;
    localparam int POWER_UP_TIMER_CYCLES      = POWER_UP_TIMER_TIME_MS * CLK_FREQ_KHZ;
    localparam int POR_DELAY_CYCLES = 16;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage
`default_nettype wire

// ### logic/rsc_timer_if.sv
/*
 * Interface between the combiner and its release delay timer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface rsc_timer_if #(parameter int W = 24);
    logic         start;
    logic [W-1:0] loadCycles;
    logic         busy;
    modport ctrl  (output start, output loadCycles, input busy);
    modport timer (input start, input loadCycles, output busy);
endinterface
`default_nettype wire

// ### logic/rsc_delay_timer.sv
/*
 * Release delay timer: counts down a loaded number of cycles, busy meanwhile.
 * Assumes start is a one-cycle pulse from the same clock domain.
 */
`timescale 1ns/10ps
`default_nettype none
module rsc_delay_timer #(
    parameter int W = 24
) (
    input  wire logic clk,
    input  wire logic rst,
    rsc_timer_if.timer tmr
);
    logic [W-1:0] count;
    logic [W-1:0] next_count;

    always_comb begin
        next_count = count;
        if (tmr.start) begin
            next_count = tmr.loadCycles;
        end else if (count != '0) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign tmr.busy = (count != '0);

    chk_load_busy : assert property (@(posedge clk) disable iff (rst)
        tmr.start && tmr.loadCycles > 1 |=> tmr.busy [*2])
        else $error("timer not busy after load");

endmodule // rsc_delay_timer
`default_nettype wire

// ### bench/rsc_src_model.sv
/* Reset source model: drives the nine reset source lines.
   Assumes the bench requests sources on the rising edge of clk. */
`timescale 1ns/10ps
`default_nettype none
module rsc_src_model (
    input  wire logic       clk,
    input  wire logic [8:0] fire,
    output logic      [8:0] src
);
    // =========================================================
    // sources stay active as long as they are requested
    always_ff @(posedge clk) begin
        src <= fire;
    end
endmodule // rsc_src_model
`default_nettype wire

// ### bench/tb_reset_source_combiner.sv
/* Bench for the reset source combiner: registers over AXI4-Lite, sources.
   Assumes rsc_src_model drives the source lines. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb_reset_source_combiner;
    localparam int PW = 20;
    localparam logic [15:0] A_CAUSE = 16'h1D00, A_S0 = 16'h1D70, A_CFG = 16'h1D80;
    localparam logic [15:0] A_IST = 16'h1D88, A_IMSK = 16'h1D90;
    localparam logic [15:0] CAUSE_OF [9] = '{16'h0003, 16'h0080, 16'h0002, 16'h0002,
        16'h0040, 16'h0010, 16'h8000, 16'h4000, 16'h4000};
    logic        clk = 1'b0, rst = 1'b1;
    logic [15:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, systemResetSignal;
    logic        brownoutDetectEnable, irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [2:0]  currentOscSel;
    logic [8:0]  fire = '0, src;
    int          fail_count = 0, compares = 0, c;
    rsc_src_model partner (.clk(clk), .fire(fire), .src(src));
    reset_source_combiner #(.POWER_UP_TIMER_CYCLES(PW), .POR_DELAY_CYCLES(4)) dut (.*,
        .powerOnPin(src[0]), .externalResetPin(src[1]), .brownoutPin(src[2]),
        .lowPowerBrownoutPin(src[3]), .softwareResetReq(src[4]),
        .watchdogResetSource(src[5]), .trapConflictReq(src[6]),
        .illegalOpcodeReq(src[7]), .uninitWregReset(src[8]));
    initial forever #4 clk = ~clk;
    // =========================================================
    // bus cycles and source pulses
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, rsc_pkg::RESP_OKAY)
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e,
                      input logic [1:0] r = rsc_pkg::RESP_OKAY);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        `CHK(s_axi_rdata, {16'h0000, e})
        `CHK(s_axi_rresp, r)
    endtask
    task automatic pulse(input int i);
        @(posedge clk);
        fire[i] <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK(systemResetSignal, 1'b1)
        fire[i] <= 1'b0;
        c = 0;
        while (systemResetSignal !== 1'b0 && c < 300) begin
            @(posedge clk);
            c++;
        end
        repeat (2) @(posedge clk);
    endtask
    // =========================================================
    // scenarios
    task automatic t_regs;
        rd(A_CAUSE, 16'h0003);
        rd(A_S0, 16'h0000);
        rd(16'h0100, 16'h0000, rsc_pkg::RESP_SLVERR);
        wr(A_CAUSE, 16'h0040);
        repeat (4) @(posedge clk);
        `CHK(systemResetSignal, 1'b0)
        rd(A_CAUSE, 16'h0040);
        // clearing write lands in the cycle of the watchdog event
        fork
            wr(A_CAUSE, 16'h0000);
            pulse(5);
        join
        rd(A_CAUSE, 16'h0010);
    endtask
    task automatic t_wdt;
        wr(A_S0, 16'h1234);
        wr(A_CFG, 16'h050B);
        wr(A_IMSK, 16'h0020);
        pulse(5);
        `CHK(currentOscSel, 3'h0)
        `CHK(irq, 1'b1)
        rd(A_S0, 16'h1234);
        rd(A_IST, 16'h0020);
        pulse(2);
        `CHK(c > PW, 1'b1)
        `CHK(currentOscSel, 3'h5)
        `CHK(irq, 1'b0)
    endtask
    task automatic t_trap_por;
        wr(A_CFG, 16'h0308);
        pulse(6);
        `CHK(currentOscSel, 3'h3)
        wr(A_CFG, 16'h050B);
        pulse(0);
        `CHK(c > PW + 4, 1'b1)
        rd(A_S0, 16'h0000);
    endtask
    task automatic t_sbor;
        wr(A_CFG, 16'h0004);
        wr(A_CAUSE, 16'h2000);
        rd(A_CAUSE, 16'h2000);
        `CHK(brownoutDetectEnable, 1'b1)
        wr(A_CAUSE, 16'h0000);
        `CHK(brownoutDetectEnable, 1'b0)
        wr(A_CAUSE, 16'h2000);
        wr(A_CFG, 16'h0008);
        rd(A_CAUSE, 16'h0000);
        // switch request moves the new source into the current field
        wr(16'h1D08, 16'h0601);
        rd(16'h1D08, 16'h6600);
        `CHK(currentOscSel, 3'h6)
    endtask
    task automatic t_all;
        for (int i = 0; i < 9; i++) begin
            wr(A_CAUSE, 16'h0000);
            pulse(i);
            rd(A_CAUSE, CAUSE_OF[i]);
        end
    endtask
    task automatic end_of_test;
        if (fail_count == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_wdt();
        t_trap_por();
        t_sbor();
        t_all();
        end_of_test();
    end
endmodule // tb_reset_source_combiner
`default_nettype wire
